// >>> src/psld_pkg.sv
`default_nettype none
package psld_pkg;

    // ---------------------------------------------------------------
    // Clock
    // ---------------------------------------------------------------
    localparam int CLK_HZ         = 40_000_000;
    localparam int CLK_PER_MS     = CLK_HZ / 1000;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int STRETCH_MS     = 50;
    localparam int STRETCH_CYC    = STRETCH_MS * CLK_PER_MS;
    localparam int LINK_QUAL_US   = 500;
    // Least time, rounded up
    localparam int LINK_QUAL_CYC  = (LINK_QUAL_US * CLK_PER_MS + 999) / 1000;
    // Link loss limit, longest time, rounded down
    localparam int LINK_LOSS_MS   = 50;
    localparam int LINK_LOSS_CYC  = LINK_LOSS_MS * CLK_PER_MS;
    localparam int LINK_PULSE_MIN = 7;

    // ---------------------------------------------------------------
    // Counter widths
    // ---------------------------------------------------------------
    localparam int STRETCH_W      = 21;
    localparam int QUAL_W         = 15;
    localparam int LOSS_W         = 21;
    localparam int PULSE_W        = 3;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic LED_OFF      = 1'b1;

    typedef enum logic {
        PSLD_LINK_DOWN,
        PSLD_LINK_UP
    } psld_link_t;

endpackage
`default_nettype wire

// >>> src/psld_stretch_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psld_stretch_if;
    logic trig;
    logic active;
    modport src (output trig, input active);
    modport str (input trig, output active);
endinterface
`default_nettype wire

// >>> src/psld_stretch.sv
`timescale 1ns/1ps
`default_nettype none
module psld_stretch #(
    parameter int CYC = psld_pkg::STRETCH_CYC
) (
    input  wire logic    clk,
    input  wire logic    nrst,
    input  wire logic    clk_en,
    psld_stretch_if.str  sif
);
    localparam int W = psld_pkg::STRETCH_W;
    localparam logic [W-1:0] CYC_V = W'(CYC);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // ---------------------------------------------------------------
    // Monostable
    // ---------------------------------------------------------------
    // Reload on every event so steady traffic never lets the lamp blink
    always_comb begin
        cnt_d = cnt_q;
        if (sif.trig) begin
            cnt_d = CYC_V;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
        end
    end

    assign sif.active = sif.trig || (cnt_q != '0);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    restart_load_a: assert property (
        (clk_en && sif.trig) |=> (cnt_q == CYC_V))
        else $error("stretch timer not reloaded by event");
    stretch_hold_a: assert property (
        (clk_en && sif.trig) |=> sif.active [*8])
        else $error("stretch ended too early");

endmodule
`default_nettype wire

// >>> src/psld_top.sv
// Functional notes
// - The transmit lamp goes low while transmit enable is present.
// - With the transmit alternate select high it shows the disconnect flag.
// - Transmit and receive activity is stretched to about 50 ms.
// - The receive lamp goes low while carrier sense is active.
// - At 100 Mb/s link lights only after signal detect held for 500 us.
// - At 100 Mb/s link goes off at once when signal detect drops.
// - At 10 Mb/s link lights after seven good link pulses or a packet.
// - At 10 Mb/s link goes off only when the link loss timer expires.
// - By default the polarity lamp goes low on a corrected inversion at 10 Mb/s.
// - With the polarity alternate select high it shows full duplex.
// - The collision lamp shows collisions in half duplex, off in full.
`timescale 1ns/1ps
`default_nettype none
module psld_top #(
    parameter int STRETCH_CYC   = psld_pkg::STRETCH_CYC,
    parameter int LINK_QUAL_CYC = psld_pkg::LINK_QUAL_CYC,
    parameter int LINK_LOSS_CYC = psld_pkg::LINK_LOSS_CYC
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic clk_en,
    input  wire logic speed_100,
    input  wire logic full_duplex,
    input  wire logic transmit_enable_internal,
    input  wire logic carrier_sense,
    input  wire logic collision,
    input  wire logic signal_detect_in,
    input  wire logic link_pulse,
    input  wire logic link_pulse_bad,
    input  wire logic valid_packet,
    input  wire logic polarity_inverted,
    input  wire logic tx_indicator_alt_select,
    input  wire logic polarity_indicator_alt_select,
    input  wire logic disconnect_state_flag,
    output logic      tx_activity_indicator_n,
    output logic      rx_activity_indicator_n,
    output logic      link_good_indicator_n,
    output logic      polarity_duplex_indicator_n,
    output logic      collision_indicator_n
);
    localparam int QW = psld_pkg::QUAL_W;
    localparam int LW = psld_pkg::LOSS_W;
    localparam int PW = psld_pkg::PULSE_W;
    localparam logic [QW-1:0] QUAL_V  = QW'(LINK_QUAL_CYC);
    localparam logic [LW-1:0] LOSS_V  = LW'(LINK_LOSS_CYC - 1);
    localparam logic [PW-1:0] PULSE_V = PW'(psld_pkg::LINK_PULSE_MIN - 1);

    // ---------------------------------------------------------------
    // Activity stretchers
    // ---------------------------------------------------------------
    psld_stretch_if tx_if ();
    psld_stretch_if rx_if ();

    assign tx_if.trig = transmit_enable_internal;
    assign rx_if.trig = carrier_sense;

    psld_stretch #(
        .CYC    (STRETCH_CYC)
    ) u_tx_stretch (
        .clk    (clk),
        .nrst   (nrst),
        .clk_en (clk_en),
        .sif    (tx_if)
    );

    psld_stretch #(
        .CYC    (STRETCH_CYC)
    ) u_rx_stretch (
        .clk    (clk),
        .nrst   (nrst),
        .clk_en (clk_en),
        .sif    (rx_if)
    );

    // ---------------------------------------------------------------
    // 100 Mb/s link qualification
    // ---------------------------------------------------------------
    logic [QW-1:0] sd_cnt_q;
    logic [QW-1:0] sd_cnt_d;
    logic          link100_q;
    logic          link100_d;

    always_comb begin
        sd_cnt_d = '0;
        if (signal_detect_in) begin
            if (sd_cnt_q == QUAL_V) begin
                sd_cnt_d = sd_cnt_q;
            end else begin
                sd_cnt_d = sd_cnt_q + QW'(1);
            end
        end
        // Dropping signal detect clears at once, no hold-off
        link100_d = signal_detect_in && (sd_cnt_q == QUAL_V);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sd_cnt_q  <= '0;
            link100_q <= 1'b0;
        end else if (clk_en) begin
            sd_cnt_q  <= sd_cnt_d;
            link100_q <= link100_d;
        end
    end

    // ---------------------------------------------------------------
    // 10 Mb/s link integrity
    // ---------------------------------------------------------------
    psld_pkg::psld_link_t lst_q;
    psld_pkg::psld_link_t lst_d;
    logic [PW-1:0]        pulse_cnt_q;
    logic [PW-1:0]        pulse_cnt_d;
    logic [LW-1:0]        loss_cnt_q;
    logic [LW-1:0]        loss_cnt_d;
    logic                 link10_up;
    logic                 keep_alive;

    // Any good link pulse or valid packet restarts the loss timer; a bad pulse does not
    assign keep_alive = link_pulse || valid_packet;
    assign link10_up  = (lst_q == psld_pkg::PSLD_LINK_UP);

    always_comb begin
        lst_d       = lst_q;
        pulse_cnt_d = pulse_cnt_q;
        loss_cnt_d  = loss_cnt_q;
        case (lst_q)
            psld_pkg::PSLD_LINK_DOWN: begin
                loss_cnt_d = '0;
                if (valid_packet) begin
                    lst_d       = psld_pkg::PSLD_LINK_UP;
                    pulse_cnt_d = '0;
                end else if (link_pulse_bad) begin
                    pulse_cnt_d = '0;
                end else if (link_pulse) begin
                    if (pulse_cnt_q == PULSE_V) begin
                        lst_d       = psld_pkg::PSLD_LINK_UP;
                        pulse_cnt_d = '0;
                    end else begin
                        pulse_cnt_d = pulse_cnt_q + PW'(1);
                    end
                end
            end
            psld_pkg::PSLD_LINK_UP: begin
                pulse_cnt_d = '0;
                if (keep_alive) begin
                    loss_cnt_d = '0;
                end else if (loss_cnt_q == LOSS_V) begin
                    lst_d      = psld_pkg::PSLD_LINK_DOWN;
                    loss_cnt_d = '0;
                end else begin
                    loss_cnt_d = loss_cnt_q + LW'(1);
                end
            end
            default: begin
                lst_d       = psld_pkg::PSLD_LINK_DOWN;
                pulse_cnt_d = '0;
                loss_cnt_d  = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lst_q       <= psld_pkg::PSLD_LINK_DOWN;
            pulse_cnt_q <= '0;
            loss_cnt_q  <= '0;
        end else if (clk_en) begin
            lst_q       <= lst_d;
            pulse_cnt_q <= pulse_cnt_d;
            loss_cnt_q  <= loss_cnt_d;
        end
    end

    // ---------------------------------------------------------------
    // Lamp outputs
    // ---------------------------------------------------------------
    logic tx_n_d;
    logic rx_n_d;
    logic link_n_d;
    logic pol_n_d;
    logic col_n_d;

    always_comb begin
        if (tx_indicator_alt_select) begin
            tx_n_d = !disconnect_state_flag;
        end else begin
            tx_n_d = !tx_if.active;
        end
        rx_n_d   = !rx_if.active;
        // Live signal detect gates the lamp so a drop clears it next edge
        link_n_d = speed_100 ? !(link100_q && signal_detect_in)
                             : !link10_up;
        if (polarity_indicator_alt_select) begin
            pol_n_d = !full_duplex;
        end else begin
            // Polarity fix only exists on the 10 Mb/s path
            pol_n_d = !(polarity_inverted && !speed_100);
        end
        col_n_d = !(collision && !full_duplex);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_activity_indicator_n     <= psld_pkg::LED_OFF;
            rx_activity_indicator_n     <= psld_pkg::LED_OFF;
            link_good_indicator_n       <= psld_pkg::LED_OFF;
            polarity_duplex_indicator_n <= psld_pkg::LED_OFF;
            collision_indicator_n       <= psld_pkg::LED_OFF;
        end else if (clk_en) begin
            tx_activity_indicator_n     <= tx_n_d;
            rx_activity_indicator_n     <= rx_n_d;
            link_good_indicator_n       <= link_n_d;
            polarity_duplex_indicator_n <= pol_n_d;
            collision_indicator_n       <= col_n_d;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    tx_activity_on_a: assert property (
        (clk_en && transmit_enable_internal && !tx_indicator_alt_select)
        |=> !tx_activity_indicator_n)
        else $error("tx lamp off during transmit");
    tx_alt_show_a: assert property (
        (clk_en && tx_indicator_alt_select)
        |=> (tx_activity_indicator_n == !$past(disconnect_state_flag)))
        else $error("tx lamp not showing disconnect flag");
    rx_stretch_hold_a: assert property (
        (clk_en && carrier_sense) ##1 clk_en [*8] |=> !rx_activity_indicator_n)
        else $error("rx lamp not stretched");
    rx_activity_on_a: assert property (
        (clk_en && carrier_sense) |=> !rx_activity_indicator_n)
        else $error("rx lamp off during carrier");
    link100_qual_a: assert property (
        $rose(link100_q) |-> ($past(sd_cnt_q) == QUAL_V))
        else $error("100M link up before qualification");
    link100_drop_a: assert property (
        (clk_en && speed_100 && !signal_detect_in)
        |=> link_good_indicator_n)
        else $error("100M link not released at once");
    link10_up_a: assert property (
        $rose(link10_up) |-> ($past(valid_packet) || ($past(link_pulse)
            && !$past(link_pulse_bad) && $past(pulse_cnt_q) == PULSE_V)))
        else $error("10M link up without pulses or packet");
    link10_loss_a: assert property (
        $fell(link10_up)
        |-> ($past(loss_cnt_q) == LOSS_V && !$past(keep_alive)))
        else $error("10M link dropped before loss timer");
    pol_default_a: assert property (
        (clk_en && !polarity_indicator_alt_select && !speed_100)
        |=> (polarity_duplex_indicator_n == !$past(polarity_inverted)))
        else $error("polarity lamp wrong");
    pol_duplex_a: assert property (
        (clk_en && polarity_indicator_alt_select)
        |=> (polarity_duplex_indicator_n == !$past(full_duplex)))
        else $error("duplex lamp wrong");
    col_duplex_a: assert property (
        (clk_en && full_duplex) |=> collision_indicator_n)
        else $error("collision lamp lit in full duplex");

    link100_seen_c: cover property ($rose(link100_q));
    link10_seen_c:  cover property ($rose(link10_up));
    link10_lost_c:  cover property ($fell(link10_up));
    tx_stretch_c:   cover property (
        $fell(transmit_enable_internal) ##1 !tx_activity_indicator_n);

endmodule
`default_nettype wire

// >>> sim/psld_lamp_panel.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Lamp panel
// ---------------------------------------------------------------
// Push-pull drivers, so each pin is a clean level with no pull to mind.
// Bit order: tx, rx, link, polarity/duplex, collision.
module psld_lamp_panel (
    input  wire logic [4:0] lamp_n,
    output logic      [4:0] lit
);
    // An LED glows while its pin sinks current
    assign lit = ~lamp_n;
endmodule
`default_nettype wire

// >>> sim/phy_status_led_driver_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
end
module phy_status_led_driver_bench;
    // ---------------------------------------------------------------
    // Setup
    // ---------------------------------------------------------------
    // Short counts keep the run brief; the long waits derive from them, short settles are fixed
    localparam int SC = 20;
    localparam int QC = 10;
    localparam int LC = 30;
    logic       clk, nrst, clk_en, spd, fdx, tx, crs, col, sd;
    logic       lp, lp_bad, vpkt, pinv, tx_alt, pol_alt, dflag;
    logic [4:0] lamp_n;
    logic [4:0] lit;
    int         errors;
    int         n_checks;

    psld_top #(
        .STRETCH_CYC  (SC),
        .LINK_QUAL_CYC(QC),
        .LINK_LOSS_CYC(LC)
    ) i_dut (
        .clk                          (clk),
        .nrst                         (nrst),
        .clk_en                       (clk_en),
        .speed_100                    (spd),
        .full_duplex                  (fdx),
        .transmit_enable_internal     (tx),
        .carrier_sense                (crs),
        .collision                    (col),
        .signal_detect_in             (sd),
        .link_pulse                   (lp),
        .link_pulse_bad               (lp_bad),
        .valid_packet                 (vpkt),
        .polarity_inverted            (pinv),
        .tx_indicator_alt_select      (tx_alt),
        .polarity_indicator_alt_select(pol_alt),
        .disconnect_state_flag        (dflag),
        .tx_activity_indicator_n      (lamp_n[0]),
        .rx_activity_indicator_n      (lamp_n[1]),
        .link_good_indicator_n        (lamp_n[2]),
        .polarity_duplex_indicator_n  (lamp_n[3]),
        .collision_indicator_n        (lamp_n[4])
    );
    psld_lamp_panel i_panel (
        .lamp_n(lamp_n),
        .lit   (lit)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Drive 2 ns after the edge so the design never races the bench
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic pulse(input int kind);
        if (kind == 0) lp = 1'b1;
        else if (kind == 1) lp_bad = 1'b1;
        else vpkt = 1'b1;
        tick(1);
        lp = 1'b0;
        lp_bad = 1'b0;
        vpkt = 1'b0;
        tick(1);
    endtask

    task automatic give_verdict;
        if (errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_activity;
        tx = 1'b1;
        crs = 1'b1;
        tick(2);
        `CHK(lit[1:0], 2'h3)
        tx = 1'b0;
        crs = 1'b0;
        tick(SC - 3);
        `CHK(lit[1:0], 2'h3)
        tick(6);
        `CHK(lit[1:0], 2'h0)
    endtask

    // A second burst late in the stretch must push the end out again
    task automatic t_retrigger;
        tx = 1'b1;
        tick(1);
        tx = 1'b0;
        tick(SC - 5);
        tx = 1'b1;
        tick(1);
        tx = 1'b0;
        tick(SC - 3);
        `CHK(lit[0], 1'b1)
        tick(6);
        `CHK(lit[0], 1'b0)
    endtask

    task automatic t_tx_alt;
        tx_alt = 1'b1;
        dflag = 1'b1;
        tick(2);
        `CHK(lit[0], 1'b1)
        dflag = 1'b0;
        tx = 1'b1;
        tick(2);
        `CHK(lit[0], 1'b0)
        tx = 1'b0;
        tx_alt = 1'b0;
        tick(SC + 4);
    endtask

    task automatic t_link100;
        spd = 1'b1;
        sd = 1'b1;
        tick(QC - 1);
        `CHK(lit[2], 1'b0)
        sd = 1'b0;
        tick(1);
        sd = 1'b1;
        tick(QC - 1);
        `CHK(lit[2], 1'b0)
        tick(5);
        `CHK(lit[2], 1'b1)
        // Lamp must go dark on the very next edge after the drop
        sd = 1'b0;
        tick(1);
        `CHK(lit[2], 1'b0)
        spd = 1'b0;
    endtask

    task automatic t_link10;
        for (int i = 0; i < 6; i++) pulse(0);
        pulse(1);
        for (int i = 0; i < 6; i++) pulse(0);
        `CHK(lit[2], 1'b0)
        pulse(0);
        tick(1);
        `CHK(lit[2], 1'b1)
        tick(LC - 6);
        `CHK(lit[2], 1'b1)
        pulse(0);
        tick(LC - 6);
        `CHK(lit[2], 1'b1)
        tick(10);
        `CHK(lit[2], 1'b0)
        pulse(2);
        tick(1);
        `CHK(lit[2], 1'b1)
        tick(LC + 5);
    endtask

    task automatic t_pol_col;
        pinv = 1'b1;
        col = 1'b1;
        tick(2);
        `CHK(lit[4:3], 2'h3)
        pinv = 1'b0;
        fdx = 1'b1;
        tick(2);
        `CHK(lit[4:3], 2'h0)
        pol_alt = 1'b1;
        tick(2);
        `CHK(lit[3], 1'b1)
        spd = 1'b1;
        tick(2);
        `CHK(lit[4:3], 2'h1)
        fdx = 1'b0;
        tick(2);
        `CHK(lit[4:3], 2'h2)
        pol_alt = 1'b0;
        spd = 1'b0;
        col = 1'b0;
        tick(2);
    endtask

    // Enable low must freeze the lamps even with traffic present
    task automatic t_freeze;
        clk_en = 1'b0;
        tx = 1'b1;
        tick(4);
        `CHK(lit[0], 1'b0)
        clk_en = 1'b1;
        tick(2);
        `CHK(lit[0], 1'b1)
        tx = 1'b0;
        tick(SC + 4);
    endtask

    // Reset in mid-stretch must drop the lamps and the pending stretch
    task automatic t_reset;
        tx = 1'b1;
        crs = 1'b1;
        tick(2);
        nrst = 1'b0;
        tx = 1'b0;
        crs = 1'b0;
        tick(2);
        `CHK(lit, 5'h00)
        nrst = 1'b1;
        tick(2);
        `CHK(lit, 5'h00)
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        errors = 0;
        n_checks = 0;
        nrst = 1'b0;
        clk_en = 1'b1;
        spd = 1'b0;
        fdx = 1'b0;
        tx = 1'b0;
        crs = 1'b0;
        col = 1'b0;
        sd = 1'b0;
        lp = 1'b0;
        lp_bad = 1'b0;
        vpkt = 1'b0;
        pinv = 1'b0;
        tx_alt = 1'b0;
        pol_alt = 1'b0;
        dflag = 1'b0;
        tick(20);
        `CHK(lit, 5'h00)
        nrst = 1'b1;
        tick(2);
        t_activity();
        t_retrigger();
        t_tx_alt();
        t_link100();
        t_link10();
        t_pol_col();
        t_freeze();
        t_reset();
        give_verdict();
    end

    // Whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #(4000 * 25);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
